// >>> inc/pvc_pkg.sv
package pvc_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int NUM_PINS = 8;
  localparam int IDX_W = 3;
  localparam int PIN_W = 64;

  // ****************************************
  // command field layout and values
  // ****************************************
  localparam logic [7:0] LC_NONE = 8'h00;
  localparam logic [7:0] LC_VERIFY = 8'h08;
  localparam logic [7:0] LC_CHANGE = 8'h10;
  localparam int P2_SPEC_BIT = 7;
  localparam int P2_RFU_HI = 6;
  localparam int P2_RFU_LO = 5;
  localparam int P2_REF_HI = 4;
  localparam int P2_SEL_HI = 1;

  // ****************************************
  // counter and reset values
  // ****************************************
  localparam logic [1:0] TRIES_INIT = 2'h3;
  localparam logic [1:0] TRIES_NONE = 2'h0;
  localparam logic [PIN_W-1:0] PIN_INIT = 64'hffffffffffffffff;

  // ****************************************
  // status words
  // ****************************************
  localparam logic [15:0] SW_OK = 16'h9000;
  localparam logic [11:0] SW_RETRY_HI = 12'h63c;
  localparam logic [15:0] SW_BLOCKED = 16'h6983;
  localparam logic [15:0] SW_DISABLED = 16'h6984;
  localparam logic [15:0] SW_BAD_LEN = 16'h6700;
  localparam logic [15:0] SW_BAD_P2 = 16'h6a86;
  localparam logic [15:0] SW_NO_REF = 16'h6a88;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EVAL = 3'b010,
    ST_RESP = 3'b100
  } state_t;

  typedef struct packed {
    logic is_change;
    logic [7:0] p2;
    logic [7:0] lc;
    logic [PIN_W-1:0] pin_old;
    logic [PIN_W-1:0] pin_new;
  } cmd_t;

  typedef struct packed {
    logic [PIN_W-1:0] ref_val;
    logic [1:0] tries;
    logic blocked;
  } slot_t;

  typedef struct packed {
    logic [IDX_W-1:0] idx;
    logic set_val;
    logic [PIN_W-1:0] val;
  } rel_t;

  localparam slot_t SLOT_INIT = '{ref_val: PIN_INIT, tries: TRIES_INIT, blocked: 1'b0};

endpackage

// >>> rtl/pin_slot.sv
`timescale 1ns/100ps
`default_nettype none
module pin_slot
  import pvc_pkg::*;
(
  input wire logic core_clk,
  input wire logic nv_rstn,
  input wire logic wr_en,
  input wire slot_t wr,
  input wire logic rel_en,
  input wire logic rel_set,
  input wire logic [PIN_W-1:0] rel_val,
  output slot_t cur
);

  slot_t slot_r;
  slot_t slot_nxt;

  // ****************************************
  // persistent pin state
  // ****************************************
  // only the power-on init or a release clears a block (a matching pin also restores tries), so failures count across sessions
  always_comb begin
    slot_nxt = slot_r;
    if (rel_en) begin
      // release command wins over a same-cycle verify outcome
      slot_nxt.tries = TRIES_INIT;
      slot_nxt.blocked = 1'b0;
      if (rel_set) begin
        slot_nxt.ref_val = rel_val;
      end
    end else if (wr_en) begin
      slot_nxt = wr;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nv_rstn) begin
      slot_r <= SLOT_INIT;
    end else begin
      slot_r <= slot_nxt;
    end
  end

  assign cur = slot_r;

endmodule
`default_nettype wire

// >>> rtl/pin_verify_change_unit.sv
`timescale 1ns/100ps
`default_nettype none
module pin_verify_change_unit
  import pvc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic nv_rstn,
  input wire logic cmd_valid,
  input wire cmd_t cmd,
  output logic cmd_ready,
  input wire logic [NUM_PINS-1:0] pin_disabled,
  input wire logic rel_valid,
  input wire rel_t rel,
  output logic rsp_valid,
  output logic [15:0] rsp_sw,
  output logic [NUM_PINS-1:0] pin_verified,
  output logic [NUM_PINS-1:0] access_ok,
  output logic [NUM_PINS-1:0] pin_blocked
);

  state_t st_r;
  state_t st_nxt;
  cmd_t cmd_r;
  cmd_t cmd_nxt;
  logic rdy_r;
  logic rdy_nxt;
  logic rv_r;
  logic rv_nxt;
  logic [15:0] sw_r;
  logic [15:0] sw_nxt;
  logic [NUM_PINS-1:0] ver_r;
  logic [NUM_PINS-1:0] ver_nxt;
  logic [NUM_PINS-1:0] acc_r;
  logic [NUM_PINS-1:0] acc_nxt;
  logic [NUM_PINS-1:0] wr_en;
  slot_t slot_q [NUM_PINS];
  slot_t upd;
  slot_t cur;
  logic [IDX_W-1:0] idx;
  logic p2_bad;
  logic ref_bad;
  logic is_query;
  logic len_bad;
  logic match;
  logic dis;
  logic [1:0] dec_tries;

  // ****************************************
  // command decode
  // ****************************************
  // entries: b8 picks global/specific bank, two low bits pick the pin
  assign idx = {cmd_r.p2[P2_SPEC_BIT], cmd_r.p2[P2_SEL_HI:0]};
  assign p2_bad = (cmd_r.p2 == 8'h00) ||
                  (cmd_r.p2[P2_RFU_HI:P2_RFU_LO] != 2'h0);
  // reference numbers above the stored set are not present
  assign ref_bad = (cmd_r.p2[P2_REF_HI:P2_SEL_HI+1] != 3'h0);
  assign is_query = !cmd_r.is_change && (cmd_r.lc == LC_NONE);
  // change must carry old and new pin, verify exactly one pin
  assign len_bad = cmd_r.is_change ? (cmd_r.lc != LC_CHANGE)
                                   : (cmd_r.lc != LC_VERIFY);
  assign cur = slot_q[idx];
  assign match = (cur.ref_val == cmd_r.pin_old);
  assign dis = pin_disabled[idx];
  assign dec_tries = cur.tries - 2'h1;

  // ****************************************
  // command sequencer
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    cmd_nxt = cmd_r;
    rdy_nxt = rdy_r;
    rv_nxt = 1'b0;
    sw_nxt = sw_r;
    ver_nxt = ver_r;
    wr_en = '0;
    upd = cur;
    case (st_r)
      ST_IDLE: begin
        if (cmd_valid && rdy_r) begin
          cmd_nxt = cmd;
          rdy_nxt = 1'b0;
          st_nxt = ST_EVAL;
        end
      end
      ST_EVAL: begin
        st_nxt = ST_RESP;
        rv_nxt = 1'b1;
        if (p2_bad) begin
          sw_nxt = SW_BAD_P2;
        end else if (ref_bad) begin
          sw_nxt = SW_NO_REF;
        end else if (is_query) begin
          // counter read works in any pin state; blocked reads as 63c0
          sw_nxt = {SW_RETRY_HI, 2'h0,
                    cur.blocked ? TRIES_NONE : cur.tries};
        end else if (len_bad) begin
          sw_nxt = SW_BAD_LEN;
        end else if (cur.blocked) begin
          sw_nxt = SW_BLOCKED;
        end else if (dis) begin
          sw_nxt = SW_DISABLED;
        end else if (match) begin
          wr_en[idx] = 1'b1;
          upd.tries = TRIES_INIT;
          if (cmd_r.is_change) begin
            // slot is global, so every channel sees the new value next cycle
            upd.ref_val = cmd_r.pin_new;
          end
          // one status vector, no channel field: valid on all channels
          ver_nxt[idx] = 1'b1;
          sw_nxt = SW_OK;
        end else begin
          wr_en[idx] = 1'b1;
          upd.tries = dec_tries;
          upd.blocked = (dec_tries == TRIES_NONE);
          ver_nxt[idx] = 1'b0;
          sw_nxt = {SW_RETRY_HI, 2'h0, dec_tries};
        end
      end
      ST_RESP: begin
        st_nxt = ST_IDLE;
        rdy_nxt = 1'b1;
      end
      default: begin
        st_nxt = ST_IDLE;
        rdy_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_r <= ST_IDLE;
      cmd_r <= '0;
      rdy_r <= 1'b1;
      rv_r <= 1'b0;
      sw_r <= SW_OK;
      ver_r <= '0;
    end else begin
      st_r <= st_nxt;
      cmd_r <= cmd_nxt;
      rdy_r <= rdy_nxt;
      rv_r <= rv_nxt;
      sw_r <= sw_nxt;
      ver_r <= ver_nxt;
    end
  end

  // ****************************************
  // access conditions
  // ****************************************
  // one cycle behind the slot state; a blocked but disabled pin stays open
  always_comb begin
    acc_nxt = '0;
    for (int i = 0; i < NUM_PINS; i++) begin
      acc_nxt[i] = pin_disabled[i] ||
                   (ver_r[i] && !slot_q[i].blocked);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      acc_r <= '0;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  // ****************************************
  // pin storage
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_slot
      pin_slot u_slot (
        .core_clk(core_clk),
        .nv_rstn(nv_rstn),
        .wr_en(wr_en[g]),
        .wr(upd),
        .rel_en(rel_valid && (rel.idx == IDX_W'(g))),
        .rel_set(rel.set_val),
        .rel_val(rel.val),
        .cur(slot_q[g])
      );
      assign pin_blocked[g] = slot_q[g].blocked;

      chk_access_blocked: assert property (
        @(posedge core_clk) disable iff (!rstn || !nv_rstn)
        (slot_q[g].blocked && !pin_disabled[g]) |=> !acc_r[g]
      ) else $error("access granted on blocked pin");

      chk_access_disabled: assert property (
        @(posedge core_clk) disable iff (!rstn || !nv_rstn)
        pin_disabled[g] |=> acc_r[g]
      ) else $error("disabled pin did not open access");

      chk_release_clears: assert property (
        @(posedge core_clk) disable iff (!rstn || !nv_rstn)
        (rel_valid && rel.idx == IDX_W'(g)) |=>
          !slot_q[g].blocked && slot_q[g].tries == TRIES_INIT
      ) else $error("release did not clear pin state");
    end
  endgenerate

  assign cmd_ready = rdy_r;
  assign rsp_valid = rv_r;
  assign rsp_sw = sw_r;
  assign pin_verified = ver_r;
  assign access_ok = acc_r;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn || !nv_rstn);

  logic usable;
  assign usable = (st_r == ST_EVAL) && !p2_bad && !ref_bad &&
                  !is_query && !len_bad && !rel_valid;

  chk_verify_good: assert property (
    usable && !cmd_r.is_change && !cur.blocked && !dis && match
    |=> cur.tries == TRIES_INIT && ver_r[idx] && rsp_sw == SW_OK
  ) else $error("good pin did not restore counter");

  chk_wrong_count: assert property (
    usable && !cur.blocked && !dis && !match
    |=> rsp_valid && rsp_sw[15:4] == SW_RETRY_HI &&
        rsp_sw[1:0] == $past(cur.tries) - 2'h1 && !ver_r[idx]
  ) else $error("wrong pin status word off");

  chk_third_blocks: assert property (
    usable && !cur.blocked && !dis && !match && cur.tries == 2'h1
    |=> cur.blocked && rsp_sw == 16'h63c0
  ) else $error("third failure did not block");

  chk_blocked_sw: assert property (
    usable && cur.blocked |=> rsp_sw == SW_BLOCKED
  ) else $error("blocked pin not answered 6983");

  chk_no_compare: assert property (
    usable && (cur.blocked || dis) |=> $stable(cur) && rsp_valid
  ) else $error("pin state changed without compare");

  chk_query_count: assert property (
    st_r == ST_EVAL && !p2_bad && !ref_bad && is_query && !cur.blocked
    |=> rsp_sw == {SW_RETRY_HI, 2'h0, $past(cur.tries)}
  ) else $error("counter query wrong");

  chk_query_blocked: assert property (
    st_r == ST_EVAL && !p2_bad && !ref_bad && is_query && cur.blocked
    |=> rsp_sw == {SW_RETRY_HI, 4'h0}
  ) else $error("blocked counter query wrong");

  chk_query_static: assert property (
    st_r == ST_EVAL && is_query && !rel_valid |=> $stable(cur) && $stable(ver_r)
  ) else $error("counter query changed pin state");

  chk_no_write: assert property (
    st_r == ST_EVAL && (cur.blocked || dis) |-> wr_en == '0
  ) else $error("blocked or disabled pin written");

  chk_rsp_pulse: assert property (
    rsp_valid |=> !rsp_valid
  ) else $error("response valid held too long");

  chk_change_adopt: assert property (
    usable && cmd_r.is_change && !cur.blocked && !dis && match
    |=> cur.ref_val == cmd_r.pin_new && cur.tries == TRIES_INIT
  ) else $error("change did not adopt new pin");

  chk_change_keep: assert property (
    usable && cmd_r.is_change && !match |=> $stable(cur.ref_val)
  ) else $error("failed change altered pin");

  chk_rsp_timing: assert property (
    cmd_valid && cmd_ready |=> !cmd_ready ##1 rsp_valid ##1 !rsp_valid && cmd_ready
  ) else $error("response timing off");

endmodule
`default_nettype wire

// >>> testbench/terminal_model.sv
`timescale 1ns/100ps
`default_nettype none
module terminal_model
  import pvc_pkg::*;
(
  input wire logic core_clk,
  input wire logic cmd_ready,
  output logic cmd_valid,
  output cmd_t cmd
);
  // ****************************************
  // command issue
  // ****************************************
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end

  // held until an edge that sees ready, so a busy card never loses it
  task automatic send(input cmd_t c);
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd = c;
    while (cmd_ready !== 1'b1) begin
      @(negedge core_clk);
    end
    @(negedge core_clk);
    cmd_valid = 1'b0;
    // released fields must not keep looking valid
    cmd = cmd_t'(~c);
  endtask
endmodule
`default_nettype wire

// >>> testbench/pin_verify_change_unit_test.sv
`timescale 1ns/100ps
`default_nettype none
module pin_verify_change_unit_test
  import pvc_pkg::*;
;
  logic core_clk, rstn, nv_rstn, cmd_valid, cmd_ready, rel_valid, rsp_valid;
  cmd_t cmd;
  rel_t rel;
  logic [NUM_PINS-1:0] pin_disabled, pin_verified, access_ok, pin_blocked;
  logic [15:0] rsp_sw;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int seed = 32'hae19fb14;
  logic [PIN_W-1:0] m_pin [NUM_PINS];
  int m_tries [NUM_PINS];
  logic [NUM_PINS-1:0] m_blk, m_ver;
  logic [7:0] lcs [3] = '{LC_NONE, LC_VERIFY, LC_CHANGE};

  pin_verify_change_unit dut (.core_clk, .rstn, .nv_rstn, .cmd_valid, .cmd, .cmd_ready,
    .pin_disabled, .rel_valid, .rel, .rsp_valid, .rsp_sw, .pin_verified, .access_ok,
    .pin_blocked);
  terminal_model term (.core_clk, .cmd_ready, .cmd_valid, .cmd);

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ****************************************
  // reference model
  // ****************************************
  task automatic model(input cmd_t c, output logic [15:0] sw);
    int i;
    i = int'({c.p2[7], c.p2[1:0]});
    if (c.p2 == 8'h00 || c.p2[6:5] != 2'h0) sw = SW_BAD_P2;
    else if (c.p2[4:2] != 3'h0) sw = SW_NO_REF;
    else if (!c.is_change && c.lc == LC_NONE)
      sw = {SW_RETRY_HI, m_blk[i] ? 4'h0 : 4'(m_tries[i])};
    else if (c.lc != (c.is_change ? LC_CHANGE : LC_VERIFY)) sw = SW_BAD_LEN;
    else if (m_blk[i]) sw = SW_BLOCKED;
    else if (pin_disabled[i]) sw = SW_DISABLED;
    else if (c.pin_old == m_pin[i]) begin
      sw = SW_OK;
      m_tries[i] = 3;
      m_ver[i] = 1'b1;
      if (c.is_change) m_pin[i] = c.pin_new;
    end else begin
      m_tries[i]--;
      m_ver[i] = 1'b0;
      m_blk[i] = (m_tries[i] == 0);
      sw = {SW_RETRY_HI, 4'(m_tries[i])};
    end
  endtask

  function automatic logic [7:0] sel(input int e);
    return {e[2], 5'h00, e[1:0]};
  endfunction

  task automatic run(input logic ch, input logic [7:0] p2, input logic [7:0] lc,
                     input logic [PIN_W-1:0] po, input logic [PIN_W-1:0] pn);
    cmd_t c;
    logic [15:0] sw;
    int k;
    c = '{is_change: ch, p2: p2, lc: lc, pin_old: po, pin_new: pn};
    model(c, sw);
    term.send(c);
    k = 0;
    while (rsp_valid !== 1'b1 && k < 4) begin
      @(negedge core_clk);
      k++;
    end
    chk("rsp_delay", 16'h1, 16'(k));
    chk("rsp_valid", 16'h1, 16'(rsp_valid));
    chk("cmd_ready", 16'h0, 16'(cmd_ready));
    chk("rsp_sw", sw, rsp_sw);
    chk("pin_blocked", 16'(m_blk), 16'(pin_blocked));
    chk("pin_verified", 16'(m_ver), 16'(pin_verified));
    @(negedge core_clk);
    chk("access_ok", 16'(pin_disabled | (m_ver & ~m_blk)), 16'(access_ok));
    chk("rsp_valid_end", 16'h0, 16'(rsp_valid));
    chk("cmd_ready_end", 16'h1, 16'(cmd_ready));
    chk("rsp_sw_hold", sw, rsp_sw);
  endtask

  task automatic rel_pin(input int i, input logic sv, input logic [PIN_W-1:0] v);
    @(negedge core_clk);
    rel_valid = 1'b1;
    rel = '{idx: i[IDX_W-1:0], set_val: sv, val: v};
    @(negedge core_clk);
    rel_valid = 1'b0;
    rel = rel_t'(~rel);
    m_tries[i] = 3;
    m_blk[i] = 1'b0;
    if (sv) m_pin[i] = v;
    chk("pin_blocked", 16'(m_blk), 16'(pin_blocked));
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    rstn = 1'b0;
    nv_rstn = 1'b0;
    rel_valid = 1'b0;
    rel = '0;
    pin_disabled = 8'h04;
    m_blk = '0;
    m_ver = '0;
    for (int i = 0; i < NUM_PINS; i++) begin
      m_pin[i] = '1;
      m_tries[i] = 3;
    end
    repeat (5) @(negedge core_clk);
    rstn = 1'b1;
    nv_rstn = 1'b1;
    for (int n = 0; n < 3; n++) run(0, sel(1), LC_VERIFY, 64'h1, 64'h0);
    run(0, sel(1), LC_VERIFY, '1, 64'h0);
    run(0, sel(1), LC_NONE, '1, 64'h0);
    rel_pin(1, 1'b1, 64'h3132333435363738);
    run(0, sel(1), LC_VERIFY, 64'h3132333435363738, 64'h0);
    run(0, sel(1), LC_NONE, 64'h0, 64'h0);
    run(1, sel(5), LC_CHANGE, 64'h5, 64'haa);
    run(1, sel(5), LC_CHANGE, '1, 64'haa);
    run(0, sel(5), LC_VERIFY, '1, 64'h0);
    run(0, sel(5), LC_VERIFY, 64'haa, 64'h0);
    for (int n = 0; n < 4; n++) run(1, sel(6), LC_CHANGE, 64'h0, 64'h0);
    run(0, sel(2), LC_VERIFY, 64'h0, 64'h0);
    run(1, sel(2), LC_CHANGE, '1, 64'h0);
    run(0, sel(2), LC_NONE, 64'h0, 64'h0);
    run(0, 8'h00, LC_VERIFY, '1, 64'h0);
    run(0, 8'h41, LC_VERIFY, '1, 64'h0);
    run(0, 8'h84, LC_VERIFY, '1, 64'h0);
    run(0, sel(3), LC_CHANGE, '1, 64'h0);
    run(1, sel(3), LC_VERIFY, '1, 64'h0);
    run(0, sel(7), LC_VERIFY, 64'h0, 64'h0);
    // session reset clears security status but not the counters
    @(negedge core_clk);
    rstn = 1'b0;
    @(negedge core_clk);
    rstn = 1'b1;
    m_ver = '0;
    chk("pin_verified", 16'h0, 16'(pin_verified));
    chk("pin_blocked", 16'(m_blk), 16'(pin_blocked));
    run(0, sel(7), LC_VERIFY, 64'h0, 64'h0);
    repeat (80) begin
      int e;
      e = $unsigned($random(seed)) % 8;
      pin_disabled = 8'($random(seed)) & 8'h31;
      if (e % 3 == 0) rel_pin(e, 1'($random(seed)), m_pin[e] ^ 64'h1);
      run(1'($random(seed)), sel(e), lcs[$unsigned($random(seed)) % 3],
          ($random(seed) & 1) ? m_pin[e] : {$random(seed), $random(seed)},
          {$random(seed), $random(seed)});
    end
    stop_test();
  end
endmodule
`default_nettype wire
